// File: lbpfm_pkg.sv
// Shared constants and types for the LED boost PFM controller
package lbpfm_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;          // 100 MHz control clock
  localparam int CNT_W         = 23;          // Wide enough for the 32 ms count
  localparam int EN_QUAL_NS    = 50000;       // 50 us high to enable
  localparam int DIS_QUAL_NS   = 32000000;    // 32 ms low to shut down
  localparam int MAX_ON_NS     = 6000;        // 6 us longest switch on-time
  localparam int MIN_OFF_NS    = 400;         // 400 ns least switch off-time
  localparam int BLANK_NS      = 400;         // 400 ns feedback blanking

  // Least times round up, longest times round down
  localparam int EN_QUAL_CYC_I  = (EN_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIS_QUAL_CYC_I = DIS_QUAL_NS / CLK_PERIOD_NS;
  localparam int MAX_ON_CYC_I   = MAX_ON_NS / CLK_PERIOD_NS;
  localparam int MIN_OFF_CYC_I  = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC_I    = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0] EN_QUAL_CYC  = CNT_W'(EN_QUAL_CYC_I);
  localparam logic [CNT_W-1:0] DIS_QUAL_CYC = CNT_W'(DIS_QUAL_CYC_I);
  localparam logic [CNT_W-1:0] MAX_ON_CYC   = CNT_W'(MAX_ON_CYC_I);
  localparam logic [CNT_W-1:0] MIN_OFF_CYC  = CNT_W'(MIN_OFF_CYC_I);
  localparam logic [CNT_W-1:0] BLANK_CYC    = CNT_W'(BLANK_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ONE      = 23'h000001;

  // ==========================================================
  // Soft-start
  localparam int               SS_W     = 10;
  localparam logic [SS_W-1:0]  SS_STEP  = 10'h100;  // 256 switch cycles per step
  localparam logic [SS_W-1:0]  SS_HALF  = 10'h200;  // End of the half-limit step
  localparam logic [SS_W-1:0]  SS_ONE   = 10'h001;

  // ==========================================================
  // Types
  localparam int CMP_W  = 5;
  localparam int SYNC_W = 6;

  typedef struct packed {
    logic fb_below;   // Sense voltage below reference
    logic ilim_hit;   // Inductor current reached present limit
    logic output_overvoltage_guard;        // Output overvoltage guard active
    logic supply_undervoltage_lockout;       // Supply undervoltage lockout active
    logic otp;        // Over-temperature active
  } lbpfm_cmp_t;

  typedef enum logic [1:0] {
    LIM_QUARTER,
    LIM_HALF,
    LIM_FULL
  } lbpfm_lim_t;

  typedef struct packed {
    logic       boost_power_switch;
    logic       led_return_switch;
    lbpfm_lim_t peak_current_limit;
  } lbpfm_drv_t;

endpackage

// File: lbpfm_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module lbpfm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ==========================================================
  // Sync stages; first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// File: lbpfm_timer.sv
// Saturating interval counter with clear and compare
`timescale 1ns/10ps
module lbpfm_timer #(
  parameter int W = 23
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  // Status
  output logic              done
);

  logic [W-1:0] cnt_r;

  // ==========================================================
  // Count up to limit and hold; clear has priority
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (clr) begin
      cnt_r <= '0;
    end else if (en && (cnt_r != limit)) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign done = (cnt_r == limit);

endmodule

// File: lbpfm_ctrl.sv
// LED boost PFM controller: switch loop, soft-start, control input, faults
`timescale 1ns/10ps
module lbpfm_ctrl
  import lbpfm_pkg::*;
#(
  parameter logic [CNT_W-1:0] EN_QUAL_CYC_P  = EN_QUAL_CYC,
  parameter logic [CNT_W-1:0] DIS_QUAL_CYC_P = DIS_QUAL_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Host control input (enable and PWM dimming)
  input  wire logic       ctrl_in,
  // Analog comparator results
  input  wire lbpfm_cmp_t cmp_in,
  // Power stage drive
  output lbpfm_drv_t      drv,
  // Status
  output logic            enabled,
  output logic            soft_start_done
);

  typedef enum logic {
    ST_SHUTDOWN,
    ST_ACTIVE
  } lbpfm_state_t;

  // ==========================================================
  // Input synchronisation
  logic [SYNC_W-1:0] sync_q;
  lbpfm_cmp_t        cmp_s;
  logic              ctrl_s;
  logic              ctrl_d_r;
  logic              ctrl_rise;

  // All comparator and control inputs pass two flops
  lbpfm_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({ctrl_in, cmp_in}),
    .q    (sync_q)
  );

  assign ctrl_s = sync_q[SYNC_W-1];
  assign cmp_s  = lbpfm_cmp_t'(sync_q[CMP_W-1:0]);

  // Edge detect reads only the synchronised level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_d_r <= 1'b0;
    end else begin
      ctrl_d_r <= ctrl_s;
    end
  end

  assign ctrl_rise = ctrl_s && !ctrl_d_r;

  // ==========================================================
  // Interval timers
  logic en_done;
  logic dis_done;
  logic on_done;
  logic off_done;
  logic blank_done;
  logic sw_on_r;
  logic fault;
  logic blank;

  // High run for enable qualification; a fault restarts it so re-enable needs a fresh run
  lbpfm_timer #(.W(CNT_W)) u_en_tmr (
    .clk   (clk),
    .rstn  (rstn),
    .clr   (!ctrl_s || fault),
    .en    (1'b1),
    .limit (EN_QUAL_CYC_P - CNT_ONE),
    .done  (en_done)
  );

  // Low run for shutdown; PWM lows under the count never disable
  lbpfm_timer #(.W(CNT_W)) u_dis_tmr (
    .clk   (clk),
    .rstn  (rstn),
    .clr   (ctrl_s),
    .en    (1'b1),
    .limit (DIS_QUAL_CYC_P - CNT_ONE),
    .done  (dis_done)
  );

  // Switch on-time
  lbpfm_timer #(.W(CNT_W)) u_on_tmr (
    .clk   (clk),
    .rstn  (rstn),
    .clr   (!sw_on_r),
    .en    (1'b1),
    .limit (MAX_ON_CYC - CNT_ONE),
    .done  (on_done)
  );

  // Switch off-time
  lbpfm_timer #(.W(CNT_W)) u_off_tmr (
    .clk   (clk),
    .rstn  (rstn),
    .clr   (sw_on_r),
    .en    (1'b1),
    .limit (MIN_OFF_CYC - CNT_ONE),
    .done  (off_done)
  );

  // Feedback blanking, restarted on each control rise
  lbpfm_timer #(.W(CNT_W)) u_blank_tmr (
    .clk   (clk),
    .rstn  (rstn),
    .clr   (ctrl_rise),
    .en    (1'b1),
    .limit (BLANK_CYC),
    .done  (blank_done)
  );

  // Rise cycle itself is blanked too, so no stale compare slips through
  assign blank = ctrl_rise || !blank_done;

  // ==========================================================
  // Device state
  lbpfm_state_t st_r;
  lbpfm_state_t st_nxt;

  // Lockout and thermal faults force the device off at once
  assign fault = cmp_s.supply_undervoltage_lockout || cmp_s.otp;

  // Enable after qualified high, shut down after qualified low or fault
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_SHUTDOWN: begin
        if (en_done && ctrl_s && !fault) begin
          st_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (fault || (dis_done && !ctrl_s)) begin
          st_nxt = ST_SHUTDOWN;
        end
      end
      default: begin
        st_nxt = ST_SHUTDOWN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_SHUTDOWN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Soft-start
  logic [SS_W-1:0] ss_cnt_r;
  logic            sw_set;
  logic            sw_clr;
  lbpfm_lim_t      lim;

  // Counts finished switch cycles, so a pulse runs at the limit chosen before it began
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ss_cnt_r <= '0;
    end else if (st_r == ST_SHUTDOWN) begin
      ss_cnt_r <= '0;
    end else if (sw_clr && (ss_cnt_r != SS_HALF)) begin
      ss_cnt_r <= ss_cnt_r + SS_ONE;
    end
  end

  // Limit step chosen from the switch cycle count
  always_comb begin
    if (ss_cnt_r < SS_STEP) begin
      lim = LIM_QUARTER;
    end else if (ss_cnt_r < SS_HALF) begin
      lim = LIM_HALF;
    end else begin
      lim = LIM_FULL;
    end
  end

  // ==========================================================
  // Boost power switch loop
  // Turn-on needs feedback low, off time elapsed, no blanking, no guard
  assign sw_set = !sw_on_r && (st_r == ST_ACTIVE) && (st_nxt == ST_ACTIVE)
                  && !fault && !cmp_s.output_overvoltage_guard
                  && off_done && cmp_s.fb_below && !blank;

  // Turn-off on current limit, maximum on-time, guard, fault or shutdown
  assign sw_clr = sw_on_r && (cmp_s.ilim_hit || on_done || cmp_s.output_overvoltage_guard || fault
                  || (st_nxt != ST_ACTIVE));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_on_r <= 1'b0;
    end else if (sw_clr) begin
      sw_on_r <= 1'b0;
    end else if (sw_set) begin
      sw_on_r <= 1'b1;
    end
  end

  // ==========================================================
  // LED return switch
  logic led_r;

  // Follows control level while enabled; a qualifying rise enables and closes together
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_r <= 1'b0;
    end else begin
      led_r <= (st_nxt == ST_ACTIVE) && ctrl_s && !fault;
    end
  end

  // ==========================================================
  // Outputs
  assign drv.boost_power_switch = sw_on_r;
  assign drv.led_return_switch  = led_r;
  assign drv.peak_current_limit = lim;
  assign enabled                = (st_r == ST_ACTIVE);
  assign soft_start_done        = (ss_cnt_r == SS_HALF);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [CNT_W-1:0] hi_len_r;
  logic [CNT_W-1:0] on_len_r;
  logic [CNT_W-1:0] off_len_r;
  logic [SS_W-1:0]  pulses_r;

  // Helper run lengths, independent of the timers they check
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_len_r  <= '0;
      on_len_r  <= '0;
      off_len_r <= '0;
      pulses_r  <= '0;
    end else begin
      hi_len_r  <= ctrl_s ? ((hi_len_r == DIS_QUAL_CYC_P) ? hi_len_r
                                                          : hi_len_r + CNT_ONE) : '0;
      on_len_r  <= sw_on_r ? on_len_r + CNT_ONE : '0;
      off_len_r <= sw_on_r ? '0 : ((off_len_r == MIN_OFF_CYC) ? off_len_r
                                                              : off_len_r + CNT_ONE);
      if (!enabled) begin
        pulses_r <= '0;
      end else if ($rose(sw_on_r) && (pulses_r != SS_HALF)) begin
        pulses_r <= pulses_r + SS_ONE;
      end
    end
  end

  a_fb_turn_on: assert property ($rose(sw_on_r) |-> $past(cmp_s.fb_below) && $past(enabled))
    else $error("switch turned on without feedback below reference");
  a_ilim_turn_off: assert property (sw_on_r && cmp_s.ilim_hit |=> !sw_on_r)
    else $error("switch stayed on after current limit reached");
  a_max_on_time: assert property (sw_on_r |-> on_len_r < MAX_ON_CYC)
    else $error("switch on-time exceeded maximum");
  a_min_off_time: assert property ($rose(sw_on_r) |-> off_len_r >= MIN_OFF_CYC)
    else $error("switch turned on before minimum off time");
  a_ss_quarter: assert property ($rose(sw_on_r) && $past(pulses_r) < SS_STEP
                                 |-> drv.peak_current_limit == LIM_QUARTER)
    else $error("soft-start first step not at quarter limit");
  a_enable_qual: assert property ($rose(enabled) |-> $past(hi_len_r) >= EN_QUAL_CYC_P - CNT_ONE)
    else $error("enabled before control high long enough");
  a_ss_restart: assert property ($rose(enabled) |-> ss_cnt_r == '0 && !soft_start_done)
    else $error("soft-start not restarted on enable");
  a_shutdown_open: assert property (!enabled |-> !drv.led_return_switch && !sw_on_r)
    else $error("switch closed while shut down");
  a_led_follow: assert property (enabled && !fault && $past(enabled) |=> led_r == $past(ctrl_s))
    else $error("LED switch not following control input");
  a_short_low_kept: assert property (enabled && ctrl_s && !fault |=> enabled)
    else $error("shutdown without a qualified low period");
  a_blank_window: assert property (ctrl_rise && !sw_on_r |=> !sw_on_r [*8])
    else $error("switch turned on inside feedback blanking");
  a_ovp_hold: assert property (cmp_s.output_overvoltage_guard |=> !sw_on_r)
    else $error("switch on during overvoltage");
  a_fault_open: assert property (fault |=> !sw_on_r && !led_r && !enabled)
    else $error("switches not open during lockout or thermal fault");

  c_enabled:   cover property ($rose(enabled));
  c_ss_done:   cover property ($rose(soft_start_done));
  c_max_on:    cover property (sw_on_r && on_done && !cmp_s.ilim_hit);
  c_ovp_event: cover property (enabled && $rose(cmp_s.output_overvoltage_guard));

endmodule

// File: lbpfm_host.sv
// Host model that drives the combined enable and dimming control input
`timescale 1ns/10ps
module lbpfm_host (
  // Clock
  input  wire logic clk,
  // Control input to the device
  output logic      ctrl_in
);
  // ==========================================================
  // Drive
  // The line is never left floating, so it starts at a defined low
  initial begin
    ctrl_in = 1'b0;
  end

  // Hold one level for n cycles; the caller picks lengths that respect
  // the enable time, the dimming period and the shutdown time
  task automatic hold(input logic lvl, input int n);
    ctrl_in = lvl;
    repeat (n) @(posedge clk);
    #1;
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the LED boost PFM controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, (e), (g)); end end
module testbench;
  import lbpfm_pkg::*;
  // ==========================================================
  // Signals
  logic       clk;
  logic       rstn;
  logic       ctrl_in;
  logic       fb, ilim, output_overvoltage_guard, supply_undervoltage_lockout, otp;
  lbpfm_cmp_t cmp;
  lbpfm_drv_t drv;
  logic       enabled;
  logic       soft_start_done;
  int         miscompares, n_checks, seed;
  int         on_n, off_n, ctrl_n, n_on, dly, ovp_n, flt_n, en_cnt, i;
  logic       sw_d, en_d, done_d, ctrl_d;
  logic [2:0] h;
  bit         big;

  assign cmp = lbpfm_cmp_t'({fb, ilim, output_overvoltage_guard, supply_undervoltage_lockout, otp});

  // ==========================================================
  // Design and host
  lbpfm_ctrl #(.EN_QUAL_CYC_P(23'h000014), .DIS_QUAL_CYC_P(23'h0000C8)) dut (
    .clk(clk), .rstn(rstn), .ctrl_in(ctrl_in), .cmp_in(cmp), .drv(drv),
    .enabled(enabled), .soft_start_done(soft_start_done));
  lbpfm_host host (.clk(clk), .ctrl_in(ctrl_in));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Expectations
  function automatic lbpfm_lim_t exp_lim(input int c);
    return (c < 256) ? LIM_QUARTER : (c < 512) ? LIM_HALF : LIM_FULL;
  endfunction
  // Three sync and register stages after the current trip, capped by the on-time limit
  function automatic int exp_on(input int d);
    return (d + 4 < 600) ? d + 4 : 600;
  endfunction

  // Current comparator: trips a random number of cycles into each on-time, never while big sets the 1000-cycle delay;
  // gated by the seen turn-on so a stale count from the last pulse cannot trip it
  always @(posedge clk) begin
    #1;
    ilim = drv.boost_power_switch && sw_d && (on_n >= dly);
  end

  // Monitor on the falling edge, where all outputs have settled
  always @(negedge clk) begin
    if (!rstn) begin
      on_n = 0; off_n = 1000; ctrl_n = 1000; n_on = 0; ovp_n = 0; flt_n = 0;
      en_cnt = 0; sw_d = 0; en_d = 0; done_d = 0; ctrl_d = 0; h = 3'h0; dly = 5;
    end else begin
      if (enabled && !en_d) n_on = 0;
      if (drv.boost_power_switch && !sw_d) begin
        `CHK("off_time", 1'b1, off_n >= 40)
        `CHK("blanking", 1'b1, ctrl_n >= 41)
        `CHK("limit", exp_lim(n_on), drv.peak_current_limit)
        if (n_on == 511 || n_on == 512) `CHK("ss_done", n_on == 512, done_d)
        n_on++;
        on_n = 0;
        dly = big ? 1000 : 3 + ($unsigned($random(seed)) % 20);
      end
      if (!drv.boost_power_switch && sw_d) begin
        `CHK("on_time", 1'b1, on_n <= exp_on(dly))
        if (dly > 600) `CHK("max_on", 1'b1, on_n >= 598)
        off_n = 0;
      end
      if (drv.boost_power_switch) on_n++;
      else off_n++;
      ctrl_n = (ctrl_in && !ctrl_d) ? 0 : ctrl_n + 1;
      ovp_n = output_overvoltage_guard ? ovp_n + 1 : 0;
      flt_n = (supply_undervoltage_lockout || otp) ? flt_n + 1 : 0;
      if (ovp_n >= 4) `CHK("ovp_gate", 1'b0, drv.boost_power_switch)
      if (flt_n >= 4) begin
        `CHK("fault_sw", 2'h0, {drv.boost_power_switch, drv.led_return_switch})
        `CHK("fault_en", 1'b0, enabled)
      end
      if (!enabled && !en_d)
        `CHK("off_drive", 2'h0, {drv.boost_power_switch, drv.led_return_switch})
      if (en_cnt >= 4 && flt_n == 0) `CHK("led_follow", h[2], drv.led_return_switch)
      en_cnt = enabled ? en_cnt + 1 : 0;
      h = {h[1:0], ctrl_in};
      sw_d = drv.boost_power_switch; en_d = enabled; done_d = soft_start_done;
      ctrl_d = ctrl_in;
    end
  end

  // ==========================================================
  // Tasks
  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bounded wait for k further switch turn-ons
  task automatic wait_on(input int k);
    int tgt;
    int j;
    tgt = n_on + k;
    for (j = 0; j < k * 800 && n_on < tgt; j++) @(posedge clk);
    #1;
    if (n_on < tgt) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic enable_check();
    host.hold(1'b1, 18);
    `CHK("en_early", 1'b0, enabled)
    host.hold(1'b1, 8);
    `CHK("en_late", 1'b1, enabled)
    `CHK("ss_restart", LIM_QUARTER, drv.peak_current_limit)
    `CHK("ss_clear", 1'b0, soft_start_done)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 0; fb = 0; ilim = 0; output_overvoltage_guard = 0; supply_undervoltage_lockout = 0; otp = 0; big = 0;
    miscompares = 0; n_checks = 0; seed = 44652;
    repeat (10) @(posedge clk);
    #1;
    rstn = 1;
    `CHK("reset_drv", 4'h0, drv)
    // Too short a high run is ignored
    host.hold(1'b1, 15);
    host.hold(1'b0, 30);
    `CHK("en_refused", 1'b0, enabled)
    enable_check();
    // Full soft-start with random current trips, then forced max on-time
    fb = 1;
    wait_on(520);
    big = 1;
    wait_on(2);
    big = 0;
    wait_on(2);
    // Dimming at a slow period with short lows; device stays enabled
    for (i = 0; i < 8; i++) begin
      host.hold(1'b1, 1800 + ($unsigned($random(seed)) % 200));
      host.hold(1'b0, 40 + ($unsigned($random(seed)) % 150));
    end
    host.hold(1'b1, 60);
    `CHK("pwm_kept", 1'b1, enabled)
    // Overvoltage gates switching only
    output_overvoltage_guard = 1;
    repeat (100) @(posedge clk);
    #1;
    output_overvoltage_guard = 0;
    wait_on(3);
    `CHK("ovp_kept", 1'b1, enabled)
    // Undervoltage then over-temperature; each needs a fresh enable
    for (i = 0; i < 2; i++) begin
      if (i == 0) supply_undervoltage_lockout = 1;
      else otp = 1;
      repeat (10) @(posedge clk);
      #1;
      supply_undervoltage_lockout = 0;
      otp = 0;
      host.hold(1'b0, 5);
      enable_check();
      wait_on(5);
    end
    // Long low run: below the threshold kept, above it shut down
    host.hold(1'b0, 195);
    `CHK("low_kept", 1'b1, enabled)
    host.hold(1'b0, 20);
    `CHK("shutdown", 1'b0, enabled)
    `CHK("led_open", 1'b0, drv.led_return_switch)
    complete_run();
  end
endmodule
